// ===== hw/pfc_prot_pkg.sv
/*
 * Constants for the protection and filter configuration register bank:
 * register offsets, field positions, reset values and serial link constants.
 * Assumes an I2C host on the far side of the two-wire port.
 */
package pfc_prot_pkg;

	// Register offsets (byte addresses on the serial link)
	localparam logic [7:0] OFS_BO_THR_LO   = 8'h3a;
	localparam logic [7:0] OFS_BO_THR_HI   = 8'h3b;
	localparam logic [7:0] OFS_QUAL_TIMES  = 8'h3c;
	localparam logic [7:0] OFS_FILTER_CFG  = 8'h3d;
	localparam logic [7:0] OFS_OC_LIMIT    = 8'h44;
	localparam logic [7:0] OFS_OC_REACTION = 8'h45;
	localparam logic [7:0] OFS_OC_DELAY_LO = 8'h46;
	localparam logic [7:0] OFS_OC_DELAY_HI = 8'h47;
	localparam logic [7:0] OFS_OV_HIGH     = 8'h48;
	localparam logic [7:0] OFS_OV_LOW      = 8'h49;

	// Reset values
	localparam logic [9:0] RST_BO_THR      = 10'h0d9;
	localparam logic [7:0] RST_QUAL_TIMES  = 8'h05;
	localparam logic [7:0] RST_FILTER_CFG  = 8'h3c;
	localparam logic [6:0] RST_OC_LIMIT    = 7'h04;
	localparam logic [3:0] RST_OC_REACTION = 4'h0;
	localparam logic [9:0] RST_OC_DELAY    = 10'h1f4;
	localparam logic [6:0] RST_OV_HIGH     = 7'h6d;
	localparam logic [6:0] RST_OV_LOW      = 7'h6d;

	// Field positions
	localparam int BRIN_TIME_MSB   = 7;
	localparam int BRIN_TIME_LSB   = 4;
	localparam int BROUT_TIME_MSB  = 3;
	localparam int BROUT_TIME_LSB  = 0;
	localparam int REF_FILT_BIT    = 5;
	localparam int DELAY_FILT_BIT  = 4;
	localparam int CUTOFF_MSB      = 3;
	localparam int CUTOFF_LSB      = 0;
	localparam int REACTION_EN_BIT = 3;

	// Over-current reaction codes
	localparam logic [2:0] REACT_LATCH  = 3'h0;
	localparam logic [2:0] REACT_HICCUP = 3'h7;

	// Serial link
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a; // arbitrary value
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
		ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
	} link_state_t;

endpackage

// ===== hw/pfc_protection_config_regs.sv
/*
 * Protection and filter configuration register bank with its own two-wire
 * (I2C) slave port: 7-bit address, one pointer byte, auto-incrementing
 * reads and writes. Assumes the two-wire pins are pulled up outside and
 * that the bus is much slower than core_clk (125 MHz).
 */
// Functional notes
// RL1 - Brown-out threshold is 10 bits at 3a/3b; upper six bits read zero; default 0d9.
// RL2 - Brown-in time in bits 7:4, brown-out time in bits 3:0; default 05.
// RL3 - Bit 5 enables reference filter, bit 4 delay-path filter; default 3c.
// RL4 - Bits 3:0 select filter corner, 0000 highest through 1111 lowest.
// RL5 - Inductor over-current limit is 7 bits, bit 7 reads zero; default 04.
// RL6 - Bit 3 enables selectable over-current reaction; bits 7:4 read zero; default 0.
// RL7 - Reaction code 000 latches off, 111 hiccups, other values give retry count.
// RL8 - Recovery delay after over-current clears is 10 bits, default 1f4, at 46/47.
// RL9 - High-line output over-voltage limit is 7 bits, default 6d.
// RL10 - Low-line output over-voltage limit is 7 bits, default 6d.
// RL11 - Low byte at lower address; writes to read-only bits ignored.
`timescale 1ns/1ps

module pfc_protection_config_regs #(
	parameter logic [6:0] DEV_ADDR = pfc_prot_pkg::DEV_ADDR_DEFAULT
) (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	output logic [9:0]      brownout_threshold,
	output logic [3:0]      brownin_qualify_time,
	output logic [3:0]      brownout_qualify_time,
	output logic            ref_smoothing_en,
	output logic            delay_path_smoothing_en,
	output logic [3:0]      cutoff_select,
	output logic [6:0]      inductor_current_limit,
	output logic            overcurrent_reaction_en,
	output logic            reaction_latch_off,
	output logic            reaction_hiccup,
	output logic [2:0]      reaction_retry_count,
	output logic [9:0]      overcurrent_recovery_delay,
	output logic [6:0]      overvoltage_limit_high_line,
	output logic [6:0]      overvoltage_limit_low_line
);

	// Pin synchronisers and glitch filter
	logic [2:0]                scl_sync_reg;
	logic [2:0]                scl_sync_next;
	logic [2:0]                sda_sync_reg;
	logic [2:0]                sda_sync_next;
	logic                      scl_f_reg;
	logic                      scl_f_next;
	logic                      sda_f_reg;
	logic                      sda_f_next;
	logic                      scl_rise;
	logic                      scl_fall;
	logic                      start_cond;
	logic                      stop_cond;

	always_comb begin
		scl_sync_next = {scl_sync_reg[1:0], scl_i};
		sda_sync_next = {sda_sync_reg[1:0], sda_i};
		scl_f_next    = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
		sda_f_next    = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
		scl_rise      = scl_f_next & ~scl_f_reg;
		scl_fall      = ~scl_f_next & scl_f_reg;
		start_cond    = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
		stop_cond     = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_f_reg    <= 1'b1;
			sda_f_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			scl_f_reg    <= scl_f_next;
			sda_f_reg    <= sda_f_next;
		end
	end

	// Link engine and configuration storage
	pfc_prot_pkg::link_state_t state_reg;
	pfc_prot_pkg::link_state_t state_next;
	logic [3:0]                bit_cnt_reg;
	logic [3:0]                bit_cnt_next;
	logic [7:0]                shift_reg;
	logic [7:0]                shift_next;
	logic [7:0]                ptr_reg;
	logic [7:0]                ptr_next;
	logic                      oe_reg;
	logic                      oe_next;
	logic [9:0]                bo_thr_reg;
	logic [9:0]                bo_thr_next;
	logic [7:0]                qual_reg;
	logic [7:0]                qual_next;
	logic [7:0]                filt_reg;
	logic [7:0]                filt_next;
	logic [6:0]                oc_lim_reg;
	logic [6:0]                oc_lim_next;
	logic [3:0]                oc_react_reg;
	logic [3:0]                oc_react_next;
	logic [9:0]                oc_dly_reg;
	logic [9:0]                oc_dly_next;
	logic [6:0]                ov_hi_reg;
	logic [6:0]                ov_hi_next;
	logic [6:0]                ov_lo_reg;
	logic [6:0]                ov_lo_next;
	logic [7:0]                rd_data;
	logic [7:0]                wr_byte;

	// Pointer and bit counter steps, shared by the read and write paths
	function automatic logic [7:0] ptr_step(input logic [7:0] p);
		return p + 8'h01;
	endfunction

	function automatic logic [3:0] cnt_step(input logic [3:0] c);
		return c + 4'h1;
	endfunction

	// Read mux; unmapped addresses and read-only bits read zero
	always_comb begin
		case (ptr_reg)
			pfc_prot_pkg::OFS_BO_THR_LO:   rd_data = bo_thr_reg[7:0]; // RL11
			pfc_prot_pkg::OFS_BO_THR_HI:   rd_data = {6'h00, bo_thr_reg[9:8]}; // RL1
			pfc_prot_pkg::OFS_QUAL_TIMES:  rd_data = qual_reg; // RL2
			pfc_prot_pkg::OFS_FILTER_CFG:  rd_data = filt_reg; // RL3
			pfc_prot_pkg::OFS_OC_LIMIT:    rd_data = {1'b0, oc_lim_reg}; // RL5
			pfc_prot_pkg::OFS_OC_REACTION: rd_data = {4'h0, oc_react_reg}; // RL6
			pfc_prot_pkg::OFS_OC_DELAY_LO: rd_data = oc_dly_reg[7:0]; // RL8
			pfc_prot_pkg::OFS_OC_DELAY_HI: rd_data = {6'h00, oc_dly_reg[9:8]}; // RL8
			pfc_prot_pkg::OFS_OV_HIGH:     rd_data = {1'b0, ov_hi_reg}; // RL9
			pfc_prot_pkg::OFS_OV_LOW:      rd_data = {1'b0, ov_lo_reg}; // RL10
			default:                       rd_data = 8'h00;
		endcase
	end

	always_comb begin
		state_next    = state_reg;
		bit_cnt_next  = bit_cnt_reg;
		shift_next    = shift_reg;
		ptr_next      = ptr_reg;
		oe_next       = oe_reg;
		bo_thr_next   = bo_thr_reg;
		qual_next     = qual_reg;
		filt_next     = filt_reg;
		oc_lim_next   = oc_lim_reg;
		oc_react_next = oc_react_reg;
		oc_dly_next   = oc_dly_reg;
		ov_hi_next    = ov_hi_reg;
		ov_lo_next    = ov_lo_reg;
		wr_byte       = shift_reg;
		if (start_cond) begin
			state_next   = pfc_prot_pkg::ST_ADDR;
			bit_cnt_next = 4'h0;
			oe_next      = 1'b0;
		end else if (stop_cond) begin
			state_next = pfc_prot_pkg::ST_IDLE;
			oe_next    = 1'b0;
		end else begin
			case (state_reg)
				pfc_prot_pkg::ST_ADDR, pfc_prot_pkg::ST_PTR, pfc_prot_pkg::ST_WDATA: begin
					if (scl_rise) begin
						shift_next   = {shift_reg[6:0], sda_f_reg};
						bit_cnt_next = cnt_step(bit_cnt_reg);
					end else if (scl_fall && bit_cnt_reg == pfc_prot_pkg::BITS_PER_BYTE) begin
						bit_cnt_next = 4'h0;
						oe_next      = 1'b1;
						if (state_reg == pfc_prot_pkg::ST_ADDR) begin
							if (shift_reg[7:1] == DEV_ADDR) begin
								state_next = pfc_prot_pkg::ST_ADDR_ACK;
							end else begin
								state_next = pfc_prot_pkg::ST_IDLE;
								oe_next    = 1'b0;
							end
						end else if (state_reg == pfc_prot_pkg::ST_PTR) begin
							state_next = pfc_prot_pkg::ST_PTR_ACK;
							ptr_next   = shift_reg;
						end else begin
							state_next = pfc_prot_pkg::ST_WACK;
							ptr_next   = ptr_step(ptr_reg);
							case (ptr_reg)
								pfc_prot_pkg::OFS_BO_THR_LO:   bo_thr_next[7:0] = wr_byte; // RL11
								pfc_prot_pkg::OFS_BO_THR_HI:   bo_thr_next[9:8] = wr_byte[1:0]; // RL1
								pfc_prot_pkg::OFS_QUAL_TIMES:  qual_next = wr_byte; // RL2
								pfc_prot_pkg::OFS_FILTER_CFG:  filt_next = wr_byte; // RL3
								pfc_prot_pkg::OFS_OC_LIMIT:    oc_lim_next = wr_byte[6:0]; // RL5
								pfc_prot_pkg::OFS_OC_REACTION: oc_react_next = wr_byte[3:0]; // RL6
								pfc_prot_pkg::OFS_OC_DELAY_LO: oc_dly_next[7:0] = wr_byte; // RL8
								pfc_prot_pkg::OFS_OC_DELAY_HI: oc_dly_next[9:8] = wr_byte[1:0]; // RL8
								pfc_prot_pkg::OFS_OV_HIGH:     ov_hi_next = wr_byte[6:0]; // RL9
								pfc_prot_pkg::OFS_OV_LOW:      ov_lo_next = wr_byte[6:0]; // RL10
								default:                       ov_lo_next = ov_lo_reg;
							endcase
						end
					end
				end
				pfc_prot_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt_next = 4'h0;
						if (shift_reg[0]) begin
							state_next = pfc_prot_pkg::ST_RDATA;
							shift_next = rd_data;
							oe_next    = ~rd_data[7];
						end else begin
							state_next = pfc_prot_pkg::ST_PTR;
							oe_next    = 1'b0;
						end
					end
				end
				pfc_prot_pkg::ST_PTR_ACK, pfc_prot_pkg::ST_WACK: begin
					if (scl_fall) begin
						state_next = pfc_prot_pkg::ST_WDATA;
						oe_next    = 1'b0;
					end
				end
				pfc_prot_pkg::ST_RDATA: begin
					if (scl_rise) begin
						bit_cnt_next = cnt_step(bit_cnt_reg);
					end else if (scl_fall) begin
						if (bit_cnt_reg == pfc_prot_pkg::BITS_PER_BYTE) begin
							state_next = pfc_prot_pkg::ST_RACK;
							oe_next    = 1'b0;
							ptr_next   = ptr_step(ptr_reg);
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							oe_next    = ~shift_reg[6];
						end
					end
				end
				pfc_prot_pkg::ST_RACK: begin
					if (scl_rise && sda_f_reg) begin
						state_next = pfc_prot_pkg::ST_IDLE;
					end else if (scl_fall) begin
						state_next   = pfc_prot_pkg::ST_RDATA;
						bit_cnt_next = 4'h0;
						shift_next   = rd_data;
						oe_next      = ~rd_data[7];
					end
				end
				default: begin
					state_next = pfc_prot_pkg::ST_IDLE;
					oe_next    = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg    <= pfc_prot_pkg::ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			ptr_reg      <= 8'h00;
			oe_reg       <= 1'b0;
			bo_thr_reg   <= pfc_prot_pkg::RST_BO_THR; // RL1
			qual_reg     <= pfc_prot_pkg::RST_QUAL_TIMES; // RL2
			filt_reg     <= pfc_prot_pkg::RST_FILTER_CFG; // RL3
			oc_lim_reg   <= pfc_prot_pkg::RST_OC_LIMIT; // RL5
			oc_react_reg <= pfc_prot_pkg::RST_OC_REACTION; // RL6
			oc_dly_reg   <= pfc_prot_pkg::RST_OC_DELAY; // RL8
			ov_hi_reg    <= pfc_prot_pkg::RST_OV_HIGH; // RL9
			ov_lo_reg    <= pfc_prot_pkg::RST_OV_LOW; // RL10
		end else begin
			state_reg    <= state_next;
			bit_cnt_reg  <= bit_cnt_next;
			shift_reg    <= shift_next;
			ptr_reg      <= ptr_next;
			oe_reg       <= oe_next;
			bo_thr_reg   <= bo_thr_next;
			qual_reg     <= qual_next;
			filt_reg     <= filt_next;
			oc_lim_reg   <= oc_lim_next;
			oc_react_reg <= oc_react_next;
			oc_dly_reg   <= oc_dly_next;
			ov_hi_reg    <= ov_hi_next;
			ov_lo_reg    <= ov_lo_next;
		end
	end

	// Open-drain data pin: only ever pulls low
	assign sda_o  = 1'b0;
	assign sda_oe = oe_reg;

	// Settings toward the control loop
	assign brownout_threshold          = bo_thr_reg;
	assign brownin_qualify_time        = qual_reg[pfc_prot_pkg::BRIN_TIME_MSB:pfc_prot_pkg::BRIN_TIME_LSB]; // RL2
	assign brownout_qualify_time       = qual_reg[pfc_prot_pkg::BROUT_TIME_MSB:pfc_prot_pkg::BROUT_TIME_LSB]; // RL2
	assign ref_smoothing_en            = filt_reg[pfc_prot_pkg::REF_FILT_BIT]; // RL3
	assign delay_path_smoothing_en     = filt_reg[pfc_prot_pkg::DELAY_FILT_BIT]; // RL3
	assign cutoff_select               = filt_reg[pfc_prot_pkg::CUTOFF_MSB:pfc_prot_pkg::CUTOFF_LSB]; // RL4
	assign inductor_current_limit      = oc_lim_reg;
	assign overcurrent_reaction_en     = oc_react_reg[pfc_prot_pkg::REACTION_EN_BIT]; // RL6
	assign reaction_latch_off          = oc_react_reg[2:0] == pfc_prot_pkg::REACT_LATCH; // RL7
	assign reaction_hiccup             = oc_react_reg[2:0] == pfc_prot_pkg::REACT_HICCUP; // RL7
	assign reaction_retry_count        = (reaction_latch_off || reaction_hiccup) ? 3'h0 : oc_react_reg[2:0]; // RL7
	assign overcurrent_recovery_delay  = oc_dly_reg;
	assign overvoltage_limit_high_line = ov_hi_reg;
	assign overvoltage_limit_low_line  = ov_lo_reg;

endmodule // pfc_protection_config_regs

// ===== testbench/i2c_host_model.sv
/* Two-wire host model: drives the clock pin, pulls the data pin low.
   Assumes a pull-up on the data wire, resolved by the bench. */
`timescale 1ns/1ps

module i2c_host_model #(
	parameter int PHASE = 12
) (
	input  wire logic core_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic wt();
		repeat (PHASE) @(posedge core_clk);
		#1;
	endtask

	// One bit slot, returns the wire level seen while the clock is high
	task automatic bit_slot(input logic b, output logic r);
		sda_low = ~b;
		wt();
		scl = 1'b1;
		wt();
		r = sda_line;
		scl = 1'b0;
		wt();
	endtask

	task automatic start();
		sda_low = 1'b0;
		wt();
		scl = 1'b1;
		wt();
		sda_low = 1'b1;
		wt();
		scl = 1'b0;
		wt();
	endtask

	task automatic stop();
		sda_low = 1'b1;
		wt();
		scl = 1'b1;
		wt();
		sda_low = 1'b0;
		wt();
	endtask

	task automatic sbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
		bit_slot(1'b1, ack);
	endtask

	// Last byte is answered with a NACK
	task automatic rbyte(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
		bit_slot(last, r);
	endtask
endmodule // i2c_host_model

// ===== testbench/pfc_protection_config_regs_sva.sv
/* Checker for the protection configuration register bank.
   Sees only the top module ports; attached by the bind below. */
`timescale 1ns/1ps

module pfc_prot_checker (
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe,
	input wire logic [9:0] brownout_threshold,
	input wire logic [3:0] brownin_qualify_time,
	input wire logic [3:0] brownout_qualify_time,
	input wire logic       ref_smoothing_en,
	input wire logic       delay_path_smoothing_en,
	input wire logic [3:0] cutoff_select,
	input wire logic [6:0] inductor_current_limit,
	input wire logic       overcurrent_reaction_en,
	input wire logic       reaction_latch_off,
	input wire logic       reaction_hiccup,
	input wire logic [2:0] reaction_retry_count,
	input wire logic [9:0] overcurrent_recovery_delay,
	input wire logic [6:0] overvoltage_limit_high_line,
	input wire logic [6:0] overvoltage_limit_low_line
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_thr_reset_val: assert property ($rose(rst_b) |-> brownout_threshold == 10'h0d9)
		else $error("threshold default wrong");
	a_qual_reset_val: assert property ($rose(rst_b) |-> brownin_qualify_time == 4'h0
		&& brownout_qualify_time == 4'h5) else $error("qualify default wrong");
	a_filt_reset_val: assert property ($rose(rst_b) |-> ref_smoothing_en &&
		delay_path_smoothing_en && cutoff_select == 4'hc) else $error("filter default wrong");
	a_limit_reset_val: assert property ($rose(rst_b) |-> inductor_current_limit == 7'h04)
		else $error("limit default wrong");
	a_react_reset_val: assert property ($rose(rst_b) |-> !overcurrent_reaction_en
		&& reaction_latch_off) else $error("reaction default wrong");
	a_delay_reset_val: assert property ($rose(rst_b) |-> overcurrent_recovery_delay == 10'h1f4)
		else $error("delay default wrong");
	a_ovh_reset_val: assert property ($rose(rst_b) |-> overvoltage_limit_high_line == 7'h6d)
		else $error("high line default wrong");
	a_ovl_reset_val: assert property ($rose(rst_b) |-> overvoltage_limit_low_line == 7'h6d)
		else $error("low line default wrong");
	a_latch_excl: assert property (reaction_latch_off |-> !reaction_hiccup
		&& reaction_retry_count == 3'h0) else $error("latch decode wrong");
	a_retry_in_range: assert property (!reaction_latch_off && !reaction_hiccup
		|-> reaction_retry_count inside {[3'h1:3'h6]}) else $error("retry decode wrong");
	a_update_at_ack: assert property ($changed(inductor_current_limit)
		|| $changed(brownout_threshold) |-> ##[0:3] sda_oe) else $error("update off ack");
endmodule // pfc_prot_checker

bind pfc_protection_config_regs pfc_prot_checker chk_i (.core_clk, .rst_b, .scl_i, .sda_i,
	.sda_o, .sda_oe, .brownout_threshold, .brownin_qualify_time, .brownout_qualify_time,
	.ref_smoothing_en, .delay_path_smoothing_en, .cutoff_select, .inductor_current_limit,
	.overcurrent_reaction_en, .reaction_latch_off, .reaction_hiccup, .reaction_retry_count,
	.overcurrent_recovery_delay, .overvoltage_limit_high_line, .overvoltage_limit_low_line);

// ===== testbench/tb.sv
/* Self-checking bench for the register bank over the two-wire port.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps

module tb;
	logic       core_clk, rst_b, scl, sda_low, sda_o, sda_oe, ack;
	logic       ref_smoothing_en, delay_path_smoothing_en, overcurrent_reaction_en;
	logic       reaction_latch_off, reaction_hiccup;
	logic [2:0] reaction_retry_count;
	logic [3:0] brownin_qualify_time, brownout_qualify_time, cutoff_select;
	logic [6:0] inductor_current_limit, overvoltage_limit_high_line, overvoltage_limit_low_line;
	logic [9:0] brownout_threshold, overcurrent_recovery_delay;
	logic [7:0] q [$];
	logic [7:0] d;
	wire logic  sda_line;
	int         errors = 0;
	int         samples_checked = 0;
	localparam logic [7:0] DEF [16] = '{8'hd9, 8'h00, 8'h05, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h04, 8'h00, 8'hf4, 8'h01, 8'h6d, 8'h6d};
	localparam logic [7:0] ONES [16] = '{8'hff, 8'h03, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h7f, 8'h0f, 8'hff, 8'h03, 8'h7f, 8'h7f};

	assign sda_line = !sda_low && !(sda_oe && !sda_o);

	pfc_protection_config_regs uut (.core_clk, .rst_b, .scl_i(scl), .sda_i(sda_line), .sda_o,
		.sda_oe, .brownout_threshold, .brownin_qualify_time, .brownout_qualify_time,
		.ref_smoothing_en, .delay_path_smoothing_en, .cutoff_select, .inductor_current_limit,
		.overcurrent_reaction_en, .reaction_latch_off, .reaction_hiccup, .reaction_retry_count,
		.overcurrent_recovery_delay, .overvoltage_limit_high_line, .overvoltage_limit_low_line);
	i2c_host_model host (.core_clk, .sda_line, .scl, .sda_low);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] ptr);
		host.start();
		host.sbyte({pfc_prot_pkg::DEV_ADDR_DEFAULT, 1'b0}, ack);
		chk(ack, 1'b0);
		host.sbyte(ptr, ack);
		chk(ack, 1'b0);
		foreach (q[i]) begin
			host.sbyte(q[i], ack);
			chk(ack, 1'b0);
		end
		host.stop();
	endtask

	task automatic rd(input logic [7:0] ptr, input int n);
		host.start();
		host.sbyte({pfc_prot_pkg::DEV_ADDR_DEFAULT, 1'b0}, ack);
		host.sbyte(ptr, ack);
		host.start();
		host.sbyte({pfc_prot_pkg::DEV_ADDR_DEFAULT, 1'b1}, ack);
		chk(ack, 1'b0);
		q = {};
		for (int i = 0; i < n; i++) begin
			host.rbyte(d, i == n - 1);
			q.push_back(d);
		end
		host.stop();
	endtask

	task automatic ports(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		chk({brownout_threshold, overcurrent_recovery_delay}, a);
		chk({brownin_qualify_time, brownout_qualify_time, ref_smoothing_en,
			delay_path_smoothing_en, cutoff_select, inductor_current_limit}, b);
		chk({overcurrent_reaction_en, reaction_latch_off, reaction_hiccup,
			reaction_retry_count, overvoltage_limit_high_line, overvoltage_limit_low_line}, c);
	endtask

	task automatic reset_and_defaults();
		rst_b = 1'b0;
		repeat (8) @(posedge core_clk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		rd(8'h3a, 16);
		foreach (q[i]) chk(q[i], DEF[i]);
		ports({10'h0d9, 10'h1f4}, {8'h05, 2'b11, 4'hc, 7'h04},
			{3'b010, 3'h0, 7'h6d, 7'h6d});
	endtask

	initial begin
		repeat (90000) @(posedge core_clk);
		errors++;
		end_of_test();
	end

	initial begin
		reset_and_defaults();
		q = {};
		repeat (16) q.push_back(8'hff);
		wr(8'h3a);
		rd(8'h3a, 16);
		foreach (q[i]) chk(q[i], ONES[i]);
		ports({10'h3ff, 10'h3ff}, {8'hff, 2'b11, 4'hf, 7'h7f},
			{3'b101, 3'h0, 7'h7f, 7'h7f});
		q = {8'h34, 8'hfe};
		wr(8'h3a);
		chk(brownout_threshold, 10'h234);
		for (int c = 0; c < 8; c++) begin
			q = {{5'h01, 3'(c)}};
			wr(8'h45);
			chk({reaction_latch_off, reaction_hiccup, reaction_retry_count},
				{c == 0, c == 7, (c == 0 || c == 7) ? 3'h0 : 3'(c)});
		end
		for (int c = 0; c < 16; c++) begin
			d = {2'b10, c[0], ~c[0], 4'(c)};
			q = {d};
			wr(8'h3d);
			chk({ref_smoothing_en, delay_path_smoothing_en, cutoff_select}, d[5:0]);
		end
		rd(8'h3d, 1);
		chk(q[0], 8'haf);
		host.start();
		host.sbyte({pfc_prot_pkg::DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, ack);
		host.stop();
		chk(ack, 1'b1);
		reset_and_defaults();
		end_of_test();
	end
endmodule // tb
